// ---- rtl/epi_regs.svh ----
// Register offsets, field positions and reset values of the external pin interrupt unit
// Notes on behaviour
// - Sense field bits 1..0 pick the trigger of pin 0: 00 low level, 01 any change, 10 fall, 11 rise.
// - Pins are synchronised to the clock before edge detection; a pulse over one period requests.
// - Enable bit 1 with the global enable lets the pin 1 request reach the core at its own vector.
// - Enable bit 0 with the global enable lets the pin 0 request reach the core at its own vector.
// - Pin activity requests even when the pin is driven as an output by this chip.
// - Unused upper bits of the enable, flag, group and mask-1 registers read as zero.
// - An edge or change on pin n that triggers sets external flag bit n.
// - Flags clear on vector entry or on a written one; a written zero leaves them alone.
// - A pin flag reads as zero while that pin is set for low-level sensing.
// - A vector request rises only when a flag (or a low pin in low-level mode), its enable and the global enable are all set.
// - Group enable bits 2..0 enable groups 2 (pins 23..16), 1 (14..8) and 0 (7..0).
// - A change on any enabled pin of group n sets group flag bit n.
// - Each mask bit admits its pin to the group; mask 1 has bits 6..0 only.
// - Sense field bits 3..2 for pin 1 use the same encoding as pin 0.
// - Low-level detection needs no clocked edge logic; change and edge modes compare against the clocked delay stage.
`ifndef EPI_REGS_SVH
`define EPI_REGS_SVH
`define EPI_OFF_SENSE 4'h0
`define EPI_OFF_PIN_EN 4'h1
`define EPI_OFF_PIN_FLAG 4'h2
`define EPI_OFF_GRP_EN 4'h3
`define EPI_OFF_GRP_FLAG 4'h4
`define EPI_OFF_MASK0 4'h5
`define EPI_OFF_MASK1 4'h6
`define EPI_OFF_MASK2 4'h7
`define EPI_OFF_IRQ_STAT 4'h8
`define EPI_OFF_IRQ_MASK 4'h9
`define EPI_SENSE0_LSB 0
`define EPI_SENSE1_LSB 2
`define EPI_SENSE_MASK 8'h0f
`define EPI_PIN_MASK 8'h03
`define EPI_GRP_MASK 8'h07
`define EPI_MASK1_BITS 8'h7f
`define EPI_STAT_MASK 8'h1f
`define EPI_RESET_VAL 8'h00
`endif

// ---- rtl/epi_pkg.sv ----
// Types of the external pin interrupt unit
package epi_pkg;
  typedef enum logic [1:0] {EPI_LOW, EPI_ANY, EPI_FALL, EPI_RISE} epi_sense_e;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } epi_bus_s;
  typedef struct packed {
    logic [2:0] grp;
    logic [1:0] pin;
  } epi_src_s;
endpackage

// ---- rtl/epi_unit.sv ----
// External pin interrupt unit: two sensed pins, three change groups, register port
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "epi_regs.svh"
module epi_unit #(
  parameter int NCHG = 24
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire epi_pkg::epi_bus_s bus,
  output logic [7:0] rdata,
  // Pins
  input wire logic ext_irq_pin0,
  input wire logic ext_irq_pin1,
  input wire logic [NCHG-1:0] change_inputs,
  // Core side
  input wire logic core_global_en,
  input wire epi_pkg::epi_src_s vec_ack,
  output epi_pkg::epi_src_s vec_req,
  // Summary interrupt
  output logic irq
);
  import epi_pkg::*;

  // Elaboration check: the group layout below is fixed at 24 change inputs
  if (NCHG != 24)
  begin : g_bad_width
    $error("epi_unit supports exactly 24 change inputs");
  end

  logic [3:0] sense_r;
  logic [1:0] pin_en_r, pin_flag_r;
  logic [2:0] grp_en_r, grp_flag_r;
  logic [7:0] mask0_r, mask2_r;
  logic [6:0] mask1_r;
  logic [4:0] stat_r, smask_r;
  logic [1:0] pin_s1_r, pin_s2_r, pin_d_r;
  logic [NCHG-1:0] chg_s1_r, chg_s2_r, chg_d_r;
  logic [1:0] pin_hit, pin_low, pin_is_low;
  logic [2:0] grp_hit;
  logic [1:0] pin_flag_vis;
  logic [NCHG-1:0] chg_mask;
  logic wr_flag_pin, wr_flag_grp, wr_stat;
  logic [4:0] stat_evt;

  // Two-stage synchronisers; only the second stage feeds detection
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pin_s1_r <= 2'h3;
      pin_s2_r <= 2'h3;
      pin_d_r <= 2'h3;
      chg_s1_r <= '0;
      chg_s2_r <= '0;
      chg_d_r <= '0;
    end
    else
    begin
      pin_s1_r <= {ext_irq_pin1, ext_irq_pin0};
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
      chg_s1_r <= change_inputs;
      chg_s2_r <= chg_s1_r;
      chg_d_r <= chg_s2_r;
    end
  end

  // Sense decode per pin; the pin is read even when it is an output
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      epi_sense_e s;
      s = epi_sense_e'(sense_r[2*i +: 2]);
      pin_is_low[i] = (s == EPI_LOW);
      pin_low[i] = pin_is_low[i] && !pin_s2_r[i];
      case (s)
        EPI_LOW: pin_hit[i] = 1'b0;
        EPI_ANY: pin_hit[i] = pin_s2_r[i] ^ pin_d_r[i];
        EPI_FALL: pin_hit[i] = pin_d_r[i] && !pin_s2_r[i];
        EPI_RISE: pin_hit[i] = !pin_d_r[i] && pin_s2_r[i];
        default: pin_hit[i] = 1'b0;
      endcase
    end
  end

  // Masked change detection; the level-based compare needs no edge memory beyond one flop
  assign chg_mask = {mask2_r, 1'b0, mask1_r, mask0_r};
  assign grp_hit[0] = |((chg_s2_r[7:0] ^ chg_d_r[7:0]) & chg_mask[7:0]);
  assign grp_hit[1] = |((chg_s2_r[15:8] ^ chg_d_r[15:8]) & chg_mask[15:8]);
  assign grp_hit[2] = |((chg_s2_r[23:16] ^ chg_d_r[23:16]) & chg_mask[23:16]);

  assign wr_flag_pin = bus.wr && bus.addr == `EPI_OFF_PIN_FLAG;
  assign wr_flag_grp = bus.wr && bus.addr == `EPI_OFF_GRP_FLAG;
  assign wr_stat = bus.wr && bus.addr == `EPI_OFF_IRQ_STAT;

  // Control registers written by software
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sense_r <= '0;
      pin_en_r <= '0;
      grp_en_r <= '0;
      mask0_r <= '0;
      mask1_r <= '0;
      mask2_r <= '0;
      smask_r <= '0;
    end
    else if (bus.wr)
    begin
      case (bus.addr)
        `EPI_OFF_SENSE: sense_r <= bus.wdata[3:0];
        `EPI_OFF_PIN_EN: pin_en_r <= bus.wdata[1:0];
        `EPI_OFF_GRP_EN: grp_en_r <= bus.wdata[2:0];
        `EPI_OFF_MASK0: mask0_r <= bus.wdata;
        `EPI_OFF_MASK1: mask1_r <= bus.wdata[6:0];
        `EPI_OFF_MASK2: mask2_r <= bus.wdata;
        `EPI_OFF_IRQ_MASK: smask_r <= bus.wdata[4:0];
        default: ;
      endcase
    end
  end

  // Pin flags: a fresh trigger wins over a clear in the same cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pin_flag_r <= '0;
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (pin_hit[i])
          pin_flag_r[i] <= 1'b1;
        else if ((wr_flag_pin && bus.wdata[i]) || vec_ack.pin[i] || pin_is_low[i])
          pin_flag_r[i] <= 1'b0;
      end
    end
  end

  // Group flags, same priority as the pin flags
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      grp_flag_r <= '0;
    else
    begin
      for (int g = 0; g < 3; g++)
      begin
        if (grp_hit[g])
          grp_flag_r[g] <= 1'b1;
        else if ((wr_flag_grp && bus.wdata[g]) || vec_ack.grp[g])
          grp_flag_r[g] <= 1'b0;
      end
    end
  end

  // Events gathered in status order; a low pin counts as an event every cycle
  assign stat_evt = {grp_hit, pin_hit | pin_low};

  // Sticky event status for the summary line, bits 1..0 pins, 4..2 groups
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      stat_r <= '0;
    else
    begin
      for (int k = 0; k < 5; k++)
      begin
        if (stat_evt[k])
          stat_r[k] <= 1'b1;
        else if (wr_stat && bus.wdata[k])
          stat_r[k] <= 1'b0;
      end
    end
  end

  assign pin_flag_vis = pin_flag_r & ~pin_is_low;

  // Vector requests: level mode asks directly from the pin, so no flag is kept
  always_comb
  begin
    for (int i = 0; i < 2; i++)
      vec_req.pin[i] = core_global_en && pin_en_r[i] && (pin_flag_vis[i] || pin_low[i]);
    vec_req.grp = {3{core_global_en}} & grp_en_r & grp_flag_r;
  end

  assign irq = |(stat_r & smask_r);

  // Read data one cycle after the strobe; unused bits read zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata <= `EPI_RESET_VAL;
    else if (bus.rd)
    begin
      case (bus.addr)
        `EPI_OFF_SENSE: rdata <= {4'h0, sense_r};
        `EPI_OFF_PIN_EN: rdata <= {6'h00, pin_en_r};
        `EPI_OFF_PIN_FLAG: rdata <= {6'h00, pin_flag_vis};
        `EPI_OFF_GRP_EN: rdata <= {5'h00, grp_en_r};
        `EPI_OFF_GRP_FLAG: rdata <= {5'h00, grp_flag_r};
        `EPI_OFF_MASK0: rdata <= mask0_r;
        `EPI_OFF_MASK1: rdata <= {1'b0, mask1_r};
        `EPI_OFF_MASK2: rdata <= mask2_r;
        `EPI_OFF_IRQ_STAT: rdata <= {3'h0, stat_r};
        `EPI_OFF_IRQ_MASK: rdata <= {3'h0, smask_r};
        default: rdata <= 8'h00;
      endcase
    end
    else
      rdata <= 8'h00;
  end

  // Named steps of the sense checks; each pairs a synchronised pin with its sense field
  sequence s_fall0;
    pin_d_r[0] && !pin_s2_r[0] && sense_r[1:0] == 2'h2;
  endsequence

  sequence s_rise0;
    !pin_d_r[0] && pin_s2_r[0] && sense_r[1:0] == 2'h3;
  endsequence

  sequence s_fall1;
    pin_d_r[1] && !pin_s2_r[1] && sense_r[3:2] == 2'h2;
  endsequence

  sequence s_any1;
    pin_d_r[1] != pin_s2_r[1] && sense_r[3:2] == 2'h1;
  endsequence

  sequence s_low0;
    sense_r[1:0] == 2'h0 && !pin_s2_r[0];
  endsequence

  // Falling edge on pin 0 sets its flag one cycle later
  chk_fall_sets_flag: assert property (@(posedge clk) disable iff (rst)
    s_fall0 |=> pin_flag_r[0]) else $error("pin 0 fall did not set flag");

  // Low-level mode hides the pin 0 flag
  chk_low_flag_hidden: assert property (@(posedge clk) disable iff (rst)
    sense_r[1:0] == 2'h0 |-> !pin_flag_vis[0]) else $error("pin 0 flag visible in low mode");

  // Nothing reaches the core while the global enable is low
  chk_req_needs_gie: assert property (@(posedge clk) disable iff (rst)
    !core_global_en |-> vec_req == '0) else $error("request without global enable");

  // Pin 1 is silent while its enable bit is clear
  chk_pin1_enable: assert property (@(posedge clk) disable iff (rst)
    !pin_en_r[1] |-> !vec_req.pin[1]) else $error("pin 1 request while disabled");

  // Pin 0 requests only with both enables
  chk_pin0_enable: assert property (@(posedge clk) disable iff (rst)
    vec_req.pin[0] |-> pin_en_r[0] && core_global_en) else $error("pin 0 request bad");

  // A pin 1 rise that survives the synchroniser in rise mode is never lost
  chk_pulse_caught: assert property (@(posedge clk) disable iff (rst)
    $rose(pin_s2_r[1]) && sense_r[3:2] == 2'h3 |=> pin_flag_r[1])
    else $error("pin 1 rise lost");

  // Group 1 change reaches its flag
  chk_group_change: assert property (@(posedge clk) disable iff (rst)
    grp_hit[1] |=> grp_flag_r[1]) else $error("group 1 change lost");

  // An empty mask silences group 0
  chk_mask_blocks: assert property (@(posedge clk) disable iff (rst)
    mask0_r == 8'h00 |-> !grp_hit[0]) else $error("masked group 0 changed");

  // Vector entry clears the group 2 flag
  chk_ack_clears: assert property (@(posedge clk) disable iff (rst)
    vec_ack.grp[2] && !grp_hit[2] |=> !grp_flag_r[2]) else $error("ack did not clear");

  // Mask 1 bit 7 always reads zero
  chk_upper_zero: assert property (@(posedge clk) disable iff (rst)
    $past(bus.rd) && $past(bus.addr) == `EPI_OFF_MASK1 |-> !rdata[7])
    else $error("mask 1 bit 7 not zero");

  // A written one clears group flag 0
  chk_w1c_clear: assert property (@(posedge clk) disable iff (rst)
    wr_flag_grp && bus.wdata[0] && !grp_hit[0] |=> !grp_flag_r[0])
    else $error("write one did not clear");

  // Rising edge on pin 0 sets its flag
  chk_rise_sets_flag: assert property (@(posedge clk) disable iff (rst)
    s_rise0 |=> pin_flag_r[0]) else $error("pin 0 rise did not set flag");

  // Falling edge on pin 1 sets its flag
  chk_fall1_sets_flag: assert property (@(posedge clk) disable iff (rst)
    s_fall1 |=> pin_flag_r[1]) else $error("pin 1 fall did not set flag");

  // Any change on pin 1 sets its flag
  chk_any1_sets_flag: assert property (@(posedge clk) disable iff (rst)
    s_any1 |=> pin_flag_r[1]) else $error("pin 1 change did not set flag");

  // A low pin in level mode asks the core directly, with no flag in between
  chk_low_requests: assert property (@(posedge clk) disable iff (rst)
    s_low0 && pin_en_r[0] && core_global_en |-> vec_req.pin[0])
    else $error("pin 0 low level not requested");

  // A low pin in level mode marks the summary status
  chk_low_sets_status: assert property (@(posedge clk) disable iff (rst)
    s_low0 |=> stat_r[0]) else $error("pin 0 low level not in status");

  // Rise mode ignores a falling pin
  chk_rise_skips_fall: assert property (@(posedge clk) disable iff (rst)
    pin_d_r[0] && !pin_s2_r[0] && sense_r[1:0] == 2'h3 && !pin_flag_r[0] |=> !pin_flag_r[0])
    else $error("pin 0 fall flagged in rise mode");

  // Low-level mode hides the pin 1 flag
  chk_pin1_low_hidden: assert property (@(posedge clk) disable iff (rst)
    sense_r[3:2] == 2'h0 |-> !pin_flag_vis[1]) else $error("pin 1 flag visible in low mode");

  // Pin 1 requests only with both enables
  chk_pin1_req_gated: assert property (@(posedge clk) disable iff (rst)
    vec_req.pin[1] |-> pin_en_r[1] && core_global_en) else $error("pin 1 request bad");

  // A set and enabled group 0 flag does reach the core
  chk_grp0_req_follows: assert property (@(posedge clk) disable iff (rst)
    grp_flag_r[0] && grp_en_r[0] && core_global_en |-> vec_req.grp[0])
    else $error("group 0 request missing");

  // Group 2 is silent while its enable is clear
  chk_grp2_needs_enable: assert property (@(posedge clk) disable iff (rst)
    !grp_en_r[2] |-> !vec_req.grp[2]) else $error("group 2 request while disabled");

  // Group 1 requests only with flag and both enables
  chk_grp1_req_gated: assert property (@(posedge clk) disable iff (rst)
    vec_req.grp[1] |-> grp_flag_r[1] && grp_en_r[1] && core_global_en)
    else $error("group 1 request bad");

  // Group 0 change reaches its flag
  chk_grp0_change_sets: assert property (@(posedge clk) disable iff (rst)
    grp_hit[0] |=> grp_flag_r[0]) else $error("group 0 change lost");

  // Group 2 change reaches its flag
  chk_grp2_change_sets: assert property (@(posedge clk) disable iff (rst)
    grp_hit[2] |=> grp_flag_r[2]) else $error("group 2 change lost");

  // A fresh change wins over an acknowledge in the same cycle
  chk_set_beats_ack: assert property (@(posedge clk) disable iff (rst)
    grp_hit[0] && vec_ack.grp[0] |=> grp_flag_r[0]) else $error("ack beat a change");

  // An empty mask silences group 2
  chk_mask2_blocks: assert property (@(posedge clk) disable iff (rst)
    mask2_r == 8'h00 |-> !grp_hit[2]) else $error("masked group 2 changed");

  // A written one clears pin flag 1
  chk_pin_w1c: assert property (@(posedge clk) disable iff (rst)
    wr_flag_pin && bus.wdata[1] && !pin_hit[1] |=> !pin_flag_r[1])
    else $error("write one did not clear pin flag");

  // A written zero leaves a set flag alone
  chk_zero_write_keeps: assert property (@(posedge clk) disable iff (rst)
    wr_flag_grp && !bus.wdata[1] && grp_flag_r[1] && !vec_ack.grp[1] |=> grp_flag_r[1])
    else $error("written zero cleared a flag");

  // Vector entry clears the pin 0 flag
  chk_pin_ack_clears: assert property (@(posedge clk) disable iff (rst)
    vec_ack.pin[0] && !pin_hit[0] |=> !pin_flag_r[0]) else $error("pin ack did not clear");

  // Pin flag register upper bits read zero
  chk_flag_upper_zero: assert property (@(posedge clk) disable iff (rst)
    $past(bus.rd) && $past(bus.addr) == `EPI_OFF_PIN_FLAG |-> rdata[7:2] == 6'h00)
    else $error("pin flag upper bits not zero");

  // Group flag register upper bits read zero
  chk_grp_upper_zero: assert property (@(posedge clk) disable iff (rst)
    $past(bus.rd) && $past(bus.addr) == `EPI_OFF_GRP_FLAG |-> rdata[7:3] == 5'h00)
    else $error("group flag upper bits not zero");

  // Pin enable register upper bits read zero
  chk_en_upper_zero: assert property (@(posedge clk) disable iff (rst)
    $past(bus.rd) && $past(bus.addr) == `EPI_OFF_PIN_EN |-> rdata[7:2] == 6'h00)
    else $error("pin enable upper bits not zero");

  // A written one clears a summary status bit
  chk_status_w1c: assert property (@(posedge clk) disable iff (rst)
    wr_stat && bus.wdata[2] && !grp_hit[0] |=> !stat_r[2]) else $error("status not cleared");

  // The summary line stays low with every status bit masked
  chk_irq_masked: assert property (@(posedge clk) disable iff (rst)
    smask_r == 5'h00 |-> !irq) else $error("irq with empty mask");

  // Read data stand only in the cycle after a read strobe
  chk_rdata_idle: assert property (@(posedge clk) disable iff (rst)
    !$past(bus.rd) |-> rdata == 8'h00) else $error("read data outside read cycle");

  // The edge stage always trails the second synchroniser stage by one clock
  chk_sync_order: assert property (@(posedge clk) disable iff (rst)
    pin_d_r == $past(pin_s2_r)) else $error("edge stage out of step");
endmodule // epi_unit

// ---- verif/epi_pins.sv ----
// Board-side model of the two sensed pins and the change inputs
`timescale 1ns/1ps
module epi_pins (
  // Clock
  input wire logic clk,
  // Pins
  output logic ext_irq_pin0,
  output logic ext_irq_pin1,
  output logic [23:0] change_inputs
);
  // Pins idle high as if pulled up; change inputs idle low
  initial
  begin
    ext_irq_pin0 = 1'b1;
    ext_irq_pin1 = 1'b1;
    change_inputs = 24'h000000;
  end
  // Every level is held for four clocks, so no pulse is shorter than one period
  task automatic set_pin(input int n, input logic v);
    @(posedge clk);
    if (n == 0)
      ext_irq_pin0 <= v;
    else
      ext_irq_pin1 <= v;
    repeat (4) @(posedge clk);
    #1;
  endtask
  // Toggle one change input and give the synchroniser time to pass it
  task automatic flip(input int n);
    @(posedge clk);
    change_inputs[n] <= ~change_inputs[n];
    repeat (4) @(posedge clk);
    #1;
  endtask
endmodule // epi_pins

// ---- verif/tb_top.sv ----
// Self-checking bench of the external pin interrupt unit
`timescale 1ns/1ps
`include "epi_regs.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_top;
  import epi_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  epi_bus_s bus = '0;
  logic [7:0] rdata;
  logic pin0;
  logic pin1;
  logic [23:0] chg;
  logic gen = 1'b1;
  epi_src_s ack = '0;
  epi_src_s req;
  logic irq;
  int bad_count = 0;
  int num_checks = 0;
  // Clock of 40 ns period
  always #20 clk = ~clk;
  epi_pins i_pins (.clk(clk), .ext_irq_pin0(pin0), .ext_irq_pin1(pin1), .change_inputs(chg));
  epi_unit #(.NCHG(24)) i_dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
    .ext_irq_pin0(pin0), .ext_irq_pin1(pin1), .change_inputs(chg),
    .core_global_en(gen), .vec_ack(ack), .vec_req(req), .irq(irq));
  // One-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
    @(posedge clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    #1;
    `CHK(nm, e, rdata)
  endtask
  // One-cycle acknowledge from the core
  task automatic ack_src(input logic [2:0] g, input logic [1:0] p);
    @(posedge clk);
    ack <= '{g, p};
    @(posedge clk);
    ack <= '0;
  endtask
  // Reset values, unused bits and an unmapped offset
  task automatic t_regs;
    rd(`EPI_OFF_SENSE, 8'h00, "sense");
    wr(`EPI_OFF_PIN_EN, 8'hff);
    rd(`EPI_OFF_PIN_EN, 8'h03, "pin_en");
    wr(`EPI_OFF_GRP_EN, 8'hff);
    rd(`EPI_OFF_GRP_EN, 8'h07, "grp_en");
    wr(`EPI_OFF_MASK1, 8'hff);
    rd(`EPI_OFF_MASK1, 8'h7f, "mask1");
    rd(4'hf, 8'h00, "unmapped");
  endtask
  // Falling, rising and any-change sensing on pin 0, flag cleared by a written one
  task automatic t_edges;
    for (int m = 1; m < 4; m++)
    begin
      wr(`EPI_OFF_SENSE, 8'(m));
      i_pins.set_pin(0, 1'b0);
      `CHK("req0", (m != 3), req.pin[0])
      wr(`EPI_OFF_PIN_FLAG, 8'h00);
      rd(`EPI_OFF_PIN_FLAG, {7'h00, m != 3}, "flag0");
      wr(`EPI_OFF_PIN_FLAG, 8'h01);
      i_pins.set_pin(0, 1'b1);
      rd(`EPI_OFF_PIN_FLAG, {7'h00, m != 2}, "flag0");
      wr(`EPI_OFF_PIN_FLAG, 8'h01);
      rd(`EPI_OFF_PIN_FLAG, 8'h00, "flag0");
    end
  endtask
  // Level sensing on pin 0, falling edge on pin 1 and its acknowledge
  task automatic t_level;
    wr(`EPI_OFF_SENSE, 8'h08);
    i_pins.set_pin(0, 1'b0);
    `CHK("req0", 1'b1, req.pin[0])
    rd(`EPI_OFF_PIN_FLAG, 8'h00, "flag0");
    @(posedge clk);
    gen <= 1'b0;
    #1;
    `CHK("req0", 1'b0, req.pin[0])
    @(posedge clk);
    gen <= 1'b1;
    i_pins.set_pin(1, 1'b0);
    `CHK("req1", 1'b1, req.pin[1])
    wr(`EPI_OFF_PIN_EN, 8'h01);
    #1;
    `CHK("req1", 1'b0, req.pin[1])
    ack_src(3'h0, 2'b10);
    rd(`EPI_OFF_PIN_FLAG, 8'h00, "flag1");
    i_pins.set_pin(0, 1'b1);
    i_pins.set_pin(1, 1'b1);
  endtask
  // Change groups, masks, summary interrupt and group acknowledge
  task automatic t_groups;
    wr(`EPI_OFF_IRQ_STAT, 8'h1f);
    wr(`EPI_OFF_MASK0, 8'h01);
    wr(`EPI_OFF_MASK1, 8'h01);
    wr(`EPI_OFF_MASK2, 8'h80);
    wr(`EPI_OFF_IRQ_MASK, 8'h1c);
    i_pins.flip(1);
    rd(`EPI_OFF_GRP_FLAG, 8'h00, "grp");
    `CHK("irq", 1'b0, irq)
    i_pins.flip(0);
    i_pins.flip(8);
    i_pins.flip(23);
    rd(`EPI_OFF_GRP_FLAG, 8'h07, "grp");
    `CHK("req_grp", 3'h7, req.grp)
    `CHK("irq", 1'b1, irq)
    wr(`EPI_OFF_IRQ_MASK, 8'h00);
    #1;
    `CHK("irq", 1'b0, irq)
    wr(`EPI_OFF_GRP_FLAG, 8'h02);
    rd(`EPI_OFF_GRP_FLAG, 8'h05, "grp");
    ack_src(3'h5, 2'b00);
    rd(`EPI_OFF_GRP_FLAG, 8'h00, "grp");
  endtask
  // Verdict and end of run
  task automatic give_verdict;
    if (bad_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Main sequence after 12 cycles of reset
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_edges;
    t_level;
    t_groups;
    give_verdict;
  end
  // Watchdog well beyond the roughly 180 cycles the tests need
  initial
  begin
    repeat (5000) @(posedge clk);
    bad_count++;
    give_verdict;
  end
endmodule // tb_top
